// ===== src/pvc_pdiv_if.sv
`timescale 1ns/100ps
interface pvc_pdiv_if;
	logic       load;
	logic [2:0] ratio;
	logic       vco_en;
	logic       clk_out;

	modport ctrl (output load, output ratio, output vco_en, input clk_out);
	modport div  (input load, input ratio, input vco_en, output clk_out);
endinterface : pvc_pdiv_if

// ===== src/pvc_pkg.sv
package pvc_pkg;

	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		ST_RESET = 6'h01,
		ST_LOAD  = 6'h02,
		ST_STAB  = 6'h04,
		ST_CAL   = 6'h08,
		ST_LOCK  = 6'h10,
		ST_RUN   = 6'h20
	} pvc_state_type;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] REG_SWRST   = 8'h0c;
	localparam logic [7:0] REG_PDIV1   = 8'h38;
	localparam logic [7:0] REG_CP1     = 8'h39;
	localparam logic [7:0] REG_DSM1    = 8'h42;
	localparam logic [7:0] REG_LF1     = 8'h43;
	localparam logic [7:0] REG_PDIV2   = 8'h47;
	localparam logic [7:0] REG_CP2     = 8'h48;
	localparam logic [7:0] REG_DSM2    = 8'h51;
	localparam logic [7:0] REG_LF2     = 8'h52;
	localparam logic [7:0] REG_FRAC1   = 8'h76;
	localparam logic [7:0] REG_LOWBW1  = 8'h78;
	localparam logic [7:0] REG_FRAC2   = 8'h84;
	localparam logic [7:0] REG_LOWBW2  = 8'h86;
	localparam logic [7:0] REG_STATUS  = 8'hf0;
	localparam logic [7:0] REG_AUTOMUTE = 8'hf1;

	// Field positions.
	localparam int SWRST_BIT   = 7;
	localparam int PDIV_LSB    = 2;
	localparam int DITHER_LSB  = 2;
	localparam int STAT_LOCK   = 6;
	localparam int STAT_FAIL   = 7;

	// Values after reset and pin-mode defaults.
	localparam logic [7:0] DEF_SWRST    = 8'hc0;
	localparam logic [7:0] DEF_CP       = 8'h04;
	localparam logic [7:0] DEF_DSM      = 8'h03;
	localparam logic [7:0] DEF_LF       = 8'h00;
	localparam logic [7:0] DEF_FRAC     = 8'h07;
	localparam logic [7:0] DEF_LOWBW    = 8'h00;
	localparam logic [7:0] DEF_AUTOMUTE = 8'hff;
	localparam logic [3:0][2:0] DEF_PDIV_CODE = {3'h7, 3'h4, 3'h2, 3'h1};

	// Reset timer: a least time, rounded up to whole cycles.
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_TIME_NS   = 10000;
	localparam logic [15:0] RST_CYCLES =
		16'((RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : pvc_pkg

// ===== src/pvc_pll_ctrl.sv
`timescale 1ns/100ps
module pvc_pll_ctrl
	import pvc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        powerdown_n_pin_i,
	input  wire logic [1:0]  pin_mode_i,
	input  wire logic        supply_ok_i,
	input  wire logic [1:0]  cal_done_i,
	input  wire logic [1:0]  cal_ok_i,
	input  wire logic [1:0]  lock_i,
	input  wire logic [1:0]  vco_en_i,
	output logic      [1:0]  cal_start_o,
	output logic      [1:0]  pll_en_o,
	output logic      [7:0]  mute_o,
	output logic      [7:0]  cp_current_o,
	output logic      [3:0]  dsm_order_o,
	output logic      [3:0]  dither_o,
	output logic      [63:0] lf_cfg_o,
	output logic      [5:0]  frac_cfg_o,
	output logic      [1:0]  low_bw_o,
	output logic      [1:0]  post_div_clk_o,
	output logic             in_reset_o
);

	typedef struct packed {
		pvc_state_type    st;
		logic [255:0][7:0] bank;
		logic             from_pin;
		logic [15:0]      timer;
		logic [1:0]       cal_seen;
		logic [1:0]       cal_start;
		logic             pd_load;
		logic             ack;
		logic [31:0]      dat;
	} pvc_ctrl_type;

	pvc_ctrl_type q;
	pvc_ctrl_type next_q;

	pvc_pdiv_if pd_if [2] ();

	logic [7:0] idx;
	logic       wr_take;
	logic       exit_ok;
	logic       cal_fail_ev;

	// Registers that exist; everything else reads zero and ignores writes.
	function automatic logic is_mapped(input logic [7:0] i);
		case (i)
			REG_SWRST, REG_PDIV1, REG_CP1, REG_DSM1, REG_PDIV2, REG_CP2,
			REG_DSM2, REG_FRAC1, REG_LOWBW1, REG_FRAC2, REG_LOWBW2,
			REG_STATUS, REG_AUTOMUTE: is_mapped = 1'b1;
			default: is_mapped = (i >= REG_LF1 && i <= REG_LF1 + 8'h3) ||
				(i >= REG_LF2 && i <= REG_LF2 + 8'h3);
		endcase
	endfunction : is_mapped

	// Default of one register under the selected pin mode.
	function automatic logic [7:0] def_val(input logic [7:0] i,
		input logic [1:0] m);
		case (i)
			REG_SWRST: def_val = DEF_SWRST;
			REG_PDIV1, REG_PDIV2: def_val = {3'h0, DEF_PDIV_CODE[m], 2'h0};
			REG_CP1, REG_CP2: def_val = DEF_CP;
			REG_DSM1, REG_DSM2: def_val = DEF_DSM;
			REG_FRAC1, REG_FRAC2: def_val = DEF_FRAC;
			REG_LOWBW1, REG_LOWBW2: def_val = DEF_LOWBW;
			REG_AUTOMUTE: def_val = DEF_AUTOMUTE;
			default: def_val = DEF_LF;
		endcase
	endfunction : def_val

	// Bus decode: a write lands at the edge where ack is seen high.
	assign idx     = adr_i[9:2];
	assign wr_take = cyc_i && stb_i && we_i && q.ack && sel_i[0];
	assign exit_ok = powerdown_n_pin_i && q.bank[REG_SWRST][SWRST_BIT];
	assign cal_fail_ev = (q.st == ST_CAL) && ((cal_done_i | q.cal_seen) == 2'h3)
		&& (cal_ok_i != 2'h3);

	// Bus slave, register bank and reset-to-lock sequencer.
	always_comb begin
		next_q = q;
		next_q.cal_start = 2'h0;
		next_q.pd_load = 1'b0;
		next_q.ack = cyc_i && stb_i && !q.ack;
		next_q.dat = 32'h0;
		if (next_q.ack && !we_i && is_mapped(idx)) begin
			next_q.dat = {24'h0, q.bank[idx]};
		end
		if (wr_take && is_mapped(idx)) begin
			if (idx == REG_STATUS) begin
				if (dat_i[STAT_FAIL]) begin
					next_q.bank[REG_STATUS][STAT_FAIL] = 1'b0;
				end
			end else begin
				next_q.bank[idx] = dat_i[7:0];
			end
		end
		if (cal_fail_ev) begin
			next_q.bank[REG_STATUS][STAT_FAIL] = 1'b1;
		end
		next_q.timer = (q.timer != 16'h0) ? q.timer - 16'h1 : 16'h0;
		case (q.st)
			ST_RESET: begin
				if (exit_ok) begin
					next_q.st = q.from_pin ? ST_LOAD : ST_STAB;
					next_q.timer = RST_CYCLES;
				end
			end
			ST_LOAD: begin
				for (int i = 0; i < 256; i++) begin
					if (is_mapped(8'(i)) && 8'(i) != REG_STATUS) begin
						next_q.bank[i] = def_val(8'(i), pin_mode_i);
					end
				end
				next_q.from_pin = 1'b0;
				next_q.st = ST_STAB;
				next_q.timer = RST_CYCLES;
			end
			ST_STAB: begin
				if (supply_ok_i && q.timer == 16'h0) begin
					next_q.st = ST_CAL;
					next_q.cal_start = 2'h3;
					next_q.cal_seen = 2'h0;
					next_q.pd_load = 1'b1;
				end
			end
			ST_CAL: begin
				next_q.cal_seen = q.cal_seen | cal_done_i;
				if (cal_fail_ev) begin
					next_q.st = ST_STAB;
					next_q.timer = RST_CYCLES;
				end else if ((cal_done_i | q.cal_seen) == 2'h3) begin
					next_q.st = ST_LOCK;
				end
			end
			ST_LOCK: begin
				if (lock_i == 2'h3) begin
					next_q.st = ST_RUN;
				end
			end
			ST_RUN: begin
				next_q.st = ST_RUN;
			end
			default: begin
				next_q.st = ST_RESET;
			end
		endcase
		// Either reset source overrides the sequence; the pin forces a reload.
		if (!powerdown_n_pin_i) begin
			next_q.st = ST_RESET;
			next_q.from_pin = 1'b1;
		end else if (!q.bank[REG_SWRST][SWRST_BIT]) begin
			next_q.st = ST_RESET;
		end
		next_q.bank[REG_STATUS][5:0] = next_q.st;
		next_q.bank[REG_STATUS][STAT_LOCK] = (lock_i == 2'h3) &&
			(q.st == ST_RUN);
	end

	// Power-up starts like a pin release so defaults are loaded.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= ST_LOAD;
			q.bank[REG_SWRST] <= DEF_SWRST;
			q.bank[REG_STATUS][5:0] <= ST_LOAD;
		end else begin
			q <= next_q;
		end
	end

	// One post divider per PLL, ratio taken from the register bank.
	for (genvar p = 0; p < 2; p++) begin : g_pdiv
		assign pd_if[p].load = q.pd_load;
		assign pd_if[p].ratio = (p == 0) ? q.bank[REG_PDIV1][PDIV_LSB +: 3]
			: q.bank[REG_PDIV2][PDIV_LSB +: 3];
		assign pd_if[p].vco_en = vco_en_i[p];
		assign post_div_clk_o[p] = pd_if[p].clk_out;
		pvc_post_div u_pdiv (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.pd    (pd_if[p])
		);
	end

	// Analog-facing settings come from the register bank; loop enables follow the state and mute applies only in ST_CAL.
	assign dat_o = q.dat;
	assign ack_o = q.ack;
	assign cal_start_o = q.cal_start;
	assign pll_en_o = (q.st == ST_LOCK || q.st == ST_RUN) ? 2'h3 : 2'h0;
	assign mute_o = (q.st == ST_CAL) ? q.bank[REG_AUTOMUTE] : 8'h00;
	assign cp_current_o = {q.bank[REG_CP2][3:0], q.bank[REG_CP1][3:0]};
	assign dsm_order_o = {q.bank[REG_DSM2][1:0], q.bank[REG_DSM1][1:0]};
	assign dither_o = {q.bank[REG_DSM2][DITHER_LSB +: 2],
		q.bank[REG_DSM1][DITHER_LSB +: 2]};
	assign lf_cfg_o = {q.bank[REG_LF2 + 8'h3], q.bank[REG_LF2 + 8'h2],
		q.bank[REG_LF2 + 8'h1], q.bank[REG_LF2], q.bank[REG_LF1 + 8'h3],
		q.bank[REG_LF1 + 8'h2], q.bank[REG_LF1 + 8'h1], q.bank[REG_LF1]};
	assign frac_cfg_o = {q.bank[REG_FRAC2][2:0], q.bank[REG_FRAC1][2:0]};
	assign low_bw_o = {q.bank[REG_LOWBW2][0], q.bank[REG_LOWBW1][0]};
	assign in_reset_o = (q.st == ST_RESET);

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_PIN_RESET: assert property (!powerdown_n_pin_i |=> q.st == ST_RESET)
		else $error("Power-down pin low did not reset.");
	AST_SW_RESET: assert property (wr_take && idx == REG_SWRST &&
		!dat_i[SWRST_BIT] && powerdown_n_pin_i |=> ##1 q.st == ST_RESET)
		else $error("Reset bit cleared but no reset state.");
	AST_RELOAD: assert property (q.st == ST_RESET && q.from_pin && exit_ok
		|=> q.st == ST_LOAD ##1
		q.bank[REG_PDIV1] == {3'h0, DEF_PDIV_CODE[$past(pin_mode_i)], 2'h0})
		else $error("Pin release did not reload defaults.");
	AST_KEEP: assert property (q.st == ST_RESET && !q.from_pin && exit_ok &&
		!(cyc_i && stb_i) |=> q.st == ST_STAB && $stable(q.bank[REG_CP1]))
		else $error("Software reset changed settings.");
	AST_EXIT: assert property (q.st == ST_RESET && exit_ok |=> q.st != ST_RESET)
		else $error("Reset state not left on release.");
	AST_STAB_GATE: assert property (q.st == ST_STAB && (!supply_ok_i ||
		q.timer != 16'h0) && powerdown_n_pin_i |=> q.st != ST_CAL)
		else $error("Calibration began before stabilisation.");
	AST_TIMER: assert property ($rose(q.st == ST_STAB) |-> q.timer == RST_CYCLES)
		else $error("Reset timer not started.");
	AST_MUTE: assert property (q.st == ST_CAL |-> mute_o == q.bank[REG_AUTOMUTE])
		else $error("Auto-mute outputs not muted during calibration.");
	AST_LOCK_EN: assert property ($rose(pll_en_o[0]) |-> $past(q.st) == ST_CAL &&
		$past(cal_ok_i) == 2'h3)
		else $error("Lock allowed without successful calibration.");
	AST_CP: assert property (wr_take && idx == REG_CP1 && powerdown_n_pin_i &&
		q.st != ST_LOAD |=> cp_current_o[3:0] == $past(dat_i[3:0]))
		else $error("Charge pump field not updated.");
	AST_DSM: assert property (wr_take && idx == REG_DSM2 && powerdown_n_pin_i &&
		q.st != ST_LOAD |=> {dither_o[3:2], dsm_order_o[3:2]} ==
		$past(dat_i[3:0]))
		else $error("Modulator order or dither field not updated.");

	// Reset is held while either source is low; the pin-mode load is a
	// single cycle, after which the reset timer takes over.
	AST_RESET_HOLD: assert property (
		q.st == ST_RESET && !exit_ok |=> q.st == ST_RESET)
		else $error("Reset state left while a source was still low.");
	AST_LOAD_ONE: assert property (
		q.st == ST_LOAD && powerdown_n_pin_i && q.bank[REG_SWRST][SWRST_BIT]
		|=> q.st == ST_STAB && q.timer == RST_CYCLES)
		else $error("Default load did not hand over to stabilisation.");

	// Calibration is only entered from stabilisation, with both start
	// strobes and a post divider reload in the same cycle.
	AST_CAL_ENTRY: assert property (
		$rose(q.st == ST_CAL) |-> $past(q.st) == ST_STAB &&
		cal_start_o == 2'h3 && q.pd_load)
		else $error("Calibration entered without start or reload.");
	AST_UNMUTE: assert property (
		q.st != ST_CAL |-> mute_o == 8'h00)
		else $error("Outputs muted outside calibration.");

	// A failed calibration must not reach lock: the sequencer returns to
	// stabilisation, restarts the timer and records the failure.
	AST_FAIL_BACK: assert property (
		cal_fail_ev && powerdown_n_pin_i && q.bank[REG_SWRST][SWRST_BIT]
		|=> q.st == ST_STAB && q.timer == RST_CYCLES &&
		q.bank[REG_STATUS][STAT_FAIL])
		else $error("Failed calibration not sent back to stabilisation.");
	AST_RUN_LOCK: assert property (
		q.st == ST_LOCK && lock_i == 2'h3 && exit_ok |=> q.st == ST_RUN)
		else $error("Lock acquired but sequencer did not run.");

	// Register writes reach the analog-facing settings the cycle after.
	AST_CP2: assert property (
		wr_take && idx == REG_CP2 && powerdown_n_pin_i && q.st != ST_LOAD
		|=> cp_current_o[7:4] == $past(dat_i[3:0]))
		else $error("Second charge pump field not updated.");
	AST_LF1: assert property (
		wr_take && idx == REG_LF1 && powerdown_n_pin_i && q.st != ST_LOAD
		|=> lf_cfg_o[7:0] == $past(dat_i[7:0]))
		else $error("Loop filter setting not updated.");

endmodule : pvc_pll_ctrl

// ===== src/pvc_post_div.sv
`timescale 1ns/100ps
module pvc_post_div
	import pvc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	pvc_pdiv_if.div   pd
);

	typedef struct packed {
		logic [3:0] div;
		logic [3:0] cnt;
		logic       out;
	} pvc_pdiv_type;

	pvc_pdiv_type q;
	pvc_pdiv_type next_q;

	// Counts VCO enables; the ratio is latched only on a load pulse.
	always_comb begin
		next_q = q;
		if (pd.load) begin
			next_q.div = (pd.ratio == 3'h0) ? 4'h2 : 4'({1'b0, pd.ratio}) + 4'h1;
			next_q.cnt = 4'h0;
			next_q.out = 1'b1;
		end else if (pd.vco_en) begin
			next_q.cnt = (q.cnt == q.div - 4'h1) ? 4'h0 : q.cnt + 4'h1;
			next_q.out = (next_q.cnt < (q.div >> 1));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '{div: 4'h2, cnt: 4'h0, out: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign pd.clk_out = q.out;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_PDIV_HOLD: assert property (!pd.load |=> $stable(q.div))
		else $error("Post divider ratio changed without a load.");
	AST_PDIV_WRAP: assert property (pd.vco_en && !pd.load && q.cnt == q.div - 4'h1
		|=> q.cnt == 4'h0 && q.out)
		else $error("Post divider did not wrap at its ratio.");

endmodule : pvc_post_div

// ===== testbench/pvc_analog_model.sv
`timescale 1ns/100ps
module pvc_analog_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] cal_start_i,
	input  wire logic [1:0] pll_en_i,
	input  wire logic       fail_i,
	output logic      [1:0] cal_done_o,
	output logic      [1:0] cal_ok_o,
	output logic      [1:0] lock_o,
	output logic      [1:0] vco_en_o
);
	logic [4:0] cnt;
	logic [1:0] lk;

	// Calibration ends 20 cycles after a start and fails only on command.
	// The host's divider plan keeps both detector inputs in range.
	// The success lines toggle outside the done cycle so stale values show.
	always_ff @(posedge clk_i) begin
		cal_done_o <= 2'b00;
		cal_ok_o   <= ~cal_ok_o;
		vco_en_o   <= 2'b11;
		if (rst_i || cal_start_i != 2'b00) begin
			cnt <= 5'h14;
		end else if (cnt == 5'h01) begin
			cnt        <= 5'h00;
			cal_done_o <= 2'b11;
			cal_ok_o   <= fail_i ? 2'b00 : 2'b11;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
		end
		if (rst_i)
			cal_ok_o <= 2'b01;
		lk <= (pll_en_i != 2'b11) ? 2'h0 : (lk == 2'h3 ? lk : lk + 2'h1);
	end

	// Lock shows once the loops have been enabled for three cycles.
	assign lock_o = (lk == 2'h3) ? 2'b11 : 2'b00;
endmodule : pvc_analog_model

// ===== testbench/pvc_pll_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin \
	mismatches++; $display("MISMATCH t=%0t %s", $time, m); end end
module pvc_pll_ctrl_tb;
	import pvc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        powerdown_n = 1'b1;
	logic        sup = 1'b1;
	logic        fail = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [1:0]  pmode = 2'h2;
	logic [31:0] rdat;
	logic        ack, inrst;
	logic [1:0]  cst, pen, cdone, cok, lock, vco, lbw, pdclk;
	logic [7:0]  mute, cp;
	logic [3:0]  dsm, dith;
	logic [63:0] lf;
	logic [5:0]  frac;
	int          mismatches = 0;
	int          n_compared = 0;
	int          cycles = 0;
	int          n;

	pvc_pll_ctrl dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .powerdown_n_pin_i(powerdown_n), .pin_mode_i(pmode),
		.supply_ok_i(sup), .cal_done_i(cdone), .cal_ok_i(cok),
		.lock_i(lock), .vco_en_i(vco), .cal_start_o(cst), .pll_en_o(pen),
		.mute_o(mute), .cp_current_o(cp), .dsm_order_o(dsm),
		.dither_o(dith), .lf_cfg_o(lf), .frac_cfg_o(frac), .low_bw_o(lbw),
		.post_div_clk_o(pdclk), .in_reset_o(inrst));
	pvc_analog_model anl (.clk_i(clk), .rst_i(rst), .cal_start_i(cst),
		.pll_en_i(pen), .fail_i(fail), .cal_done_o(cdone), .cal_ok_o(cok),
		.lock_o(lock), .vco_en_o(vco));

	// Free-running clock and a cycle budget that cuts a hang short.
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// One classic Wishbone cycle, held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] i,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= {i, 2'b00};
		wdat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, i, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] i, input logic [7:0] e,
		input logic [7:0] m);
		logic [7:0] q;
		wb(1'b0, i, 8'h00, q);
		`CHK(q & m, e, "register read")
	endtask : rd

	// Waits for the calibration start pulse; n = 3000 means it never came.
	task automatic wait_cal;
		n = 0;
		while (cst !== 2'b11 && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_cal

	task automatic wait_run;
		n = 0;
		while (pen !== 2'b11 && n < 200) begin
			@(posedge clk);
			n++;
		end
		`CHK(pen, 2'b11, "loops not enabled")
	endtask : wait_run

	// Measures the distance in cycles between two rises of divider c.
	task automatic per(input int c, input int e);
		int   p, k, ed;
		logic pv;
		p = 0;
		ed = 0;
		pv = pdclk[c];
		for (k = 0; k < 100 && ed < 2; k++) begin
			@(posedge clk);
			if (ed == 1)
				p++;
			if (pdclk[c] === 1'b1 && pv === 1'b0)
				ed++;
			pv = pdclk[c];
		end
		`CHK(p, e, "post divider period")
	endtask : per

	task automatic t_boot;
		wait_cal;
		`CHK(n >= RST_CYCLES && n < 3000, 1'b1, "boot timer")
		#1;
		`CHK(mute, 8'hff, "mute in cal")
		`CHK(pen, 2'b00, "enabled in cal")
		wait_run;
		#1;
		`CHK(mute, 8'h00, "mute after cal")
		rd(REG_SWRST, DEF_SWRST, 8'hff);
		rd(REG_CP1, DEF_CP, 8'h0f);
		rd(REG_DSM1, DEF_DSM, 8'h0f);
		rd(REG_PDIV1, 8'h10, 8'h1c);
		rd(8'h01, 8'h00, 8'hff);
		rd(REG_STATUS, 8'h60, 8'hff);
		per(0, 5);
		per(1, 5);
	endtask : t_boot

	// PLL one is fractional with a large even denominator, so it runs
	// second order with dithering; PLL two has a zero numerator, so integer.
	task automatic t_fields;
		logic [7:0] v [8];
		v = '{8'h21, 8'h32, 8'h01, 8'h54, 8'h65, 8'h76, 8'h00, 8'h98};
		for (int k = 0; k < 8; k++)
			wr(k < 4 ? REG_LF1 + 8'(k) : REG_LF2 + 8'(k - 4), v[k]);
		wr(REG_FRAC1, 8'h07);
		wr(REG_FRAC2, 8'h03);
		wr(REG_LOWBW1, 8'h01);
		wr(REG_CP1, 8'h0f);
		wr(REG_CP2, 8'h05);
		wr(REG_DSM1, 8'h0e);
		wr(REG_DSM2, 8'h00);
		#1;
		`CHK(lf, 64'h9800_7665_5401_3221, "loop filter")
		`CHK(frac, 6'h1f, "fraction fields")
		`CHK(lbw, 2'b01, "low bandwidth")
		`CHK(cp, 8'h5f, "charge pump")
		`CHK(dsm, 4'h2, "modulator order")
		`CHK(dith, 4'h3, "dither mode")
	endtask : t_fields

	task automatic t_soft;
		wr(REG_PDIV1, 8'h04);
		per(0, 5);
		wr(REG_DSM1, 8'h01);
		wr(REG_SWRST, 8'h40);
		repeat (2) @(posedge clk);
		#1;
		`CHK(inrst, 1'b1, "soft reset")
		wr(REG_SWRST, 8'hc0);
		wait_cal;
		`CHK(n >= RST_CYCLES && n < 3000, 1'b1, "soft timer")
		wait_run;
		rd(REG_CP1, 8'h0f, 8'h0f);
		rd(REG_DSM1, 8'h01, 8'h0f);
		per(0, 2);
		per(1, 5);
	endtask : t_soft

	task automatic t_fail;
		fail <= 1'b1;
		wr(REG_AUTOMUTE, 8'h5a);
		wr(REG_SWRST, 8'h40);
		wr(REG_SWRST, 8'hc0);
		wait_cal;
		#1;
		`CHK(mute, 8'h5a, "selected mute")
		repeat (40) @(posedge clk);
		#1;
		`CHK(pen, 2'b00, "enabled after fail")
		rd(REG_STATUS, 8'h80, 8'h80);
		fail <= 1'b0;
		wr(REG_STATUS, 8'h80);
		rd(REG_STATUS, 8'h00, 8'h80);
		wait_cal;
		wait_run;
	endtask : t_fail

	task automatic t_pin;
		pmode <= 2'h1;
		sup <= 1'b0;
		powerdown_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		`CHK(inrst, 1'b1, "pin reset")
		@(posedge clk);
		powerdown_n <= 1'b1;
		wait_cal;
		`CHK(n, 3000, "cal without supply")
		sup <= 1'b1;
		wait_cal;
		`CHK(n < 3000, 1'b1, "no cal after pin")
		wait_run;
		rd(REG_CP1, DEF_CP, 8'h0f);
		rd(REG_AUTOMUTE, DEF_AUTOMUTE, 8'hff);
		rd(REG_PDIV1, 8'h08, 8'h1c);
		per(0, 3);
		per(1, 3);
	endtask : t_pin

	// Main sequence: reset for eight cycles, then every scenario in turn.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_boot;
		t_fields;
		t_soft;
		t_fail;
		t_pin;
		wrap_up();
	end
endmodule : pvc_pll_ctrl_tb
